//--- dcpid_map.vh
`ifndef DCPID_MAP_VH
`define DCPID_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DCPID_REG_CTRL   8'h00
`define DCPID_REG_CMD    8'h04
`define DCPID_REG_TARGET 8'h08
`define DCPID_REG_SPEED  8'h0c
`define DCPID_REG_ACCEL  8'h10
`define DCPID_REG_DECEL  8'h14
`define DCPID_REG_KP     8'h18
`define DCPID_REG_KI     8'h1c
`define DCPID_REG_KD     8'h20
`define DCPID_REG_UNOM   8'h24
`define DCPID_REG_CPR    8'h28
`define DCPID_REG_STATUS 8'h2c
`define DCPID_REG_POS    8'h30
`define DCPID_REG_SETPT  8'h34
`define DCPID_REG_DUTY   8'h38

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCPID_CTRL_ACCEL 0
`define DCPID_CTRL_STOPL 1
`define DCPID_CTRL_STOPR 2
`define DCPID_CMD_MOVE   0
`define DCPID_CMD_ESTOP  1
`define DCPID_CMD_SSTOP  2
`define DCPID_ST_RUN     0
`define DCPID_ST_DONE    1
`define DCPID_ST_LIMIT   2
`define DCPID_ST_SOFT    3
`define DCPID_ST_DIR     4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DCPID_CTRL_RST   3'h1
`define DCPID_UNOM_RST   16'h0018
`define DCPID_CPR_RST    16'h1000

// ----------------------------------------
// Timing and scaling
// ----------------------------------------
`define DCPID_CLK_NS       5
`define DCPID_PERIOD_NS    1000000
`define DCPID_P_FULL_REV   256
`define DCPID_P_SHIFT      8
`define DCPID_I_FULL_X10   525
`define DCPID_D_FULL_RPM   96000
`define DCPID_FRAC         24

`endif

//--- dcpid_duty_norm.v
`timescale 1ns/1ps
`default_nettype none

// Long division num/den, one bit per cycle, result saturated to 2^QW
module dcpid_duty_norm #(
    parameter NW = 82,
    parameter DW = 32,
    parameter QW = 10
) (
    // Clock and reset
    input  wire          clk,
    input  wire          rstn,
    input  wire          ce,
    // Request
    input  wire          start,
    input  wire [NW-1:0] num,
    input  wire [DW-1:0] den,
    // Result
    output reg           done,
    output reg  [QW:0]   duty
);

    localparam [QW:0] FULL = {1'b1, {QW{1'b0}}};

    reg  [DW:0]   rem;
    reg  [NW-1:0] quo;
    reg  [NW-1:0] shiftN;
    reg  [DW-1:0] denHold;
    reg  [7:0]    cnt;
    reg           busy;
    wire [DW:0]   trial = {rem[DW-1:0], shiftN[NW-1]};
    wire          fit   = trial >= {1'b0, denHold};

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rem     <= {(DW+1){1'b0}};
            quo     <= {NW{1'b0}};
            shiftN  <= {NW{1'b0}};
            denHold <= {DW{1'b0}};
            cnt     <= 8'h00;
            busy    <= 1'b0;
            done    <= 1'b0;
            duty    <= {(QW+1){1'b0}};
        end else if (ce) begin
            done <= 1'b0;
            if (start) begin
                // A dead supply reading means no division: drive flat out
                if (den == {DW{1'b0}}) begin
                    duty <= FULL;
                    done <= 1'b1;
                end else begin
                    shiftN  <= num;
                    denHold <= den;
                    rem     <= {(DW+1){1'b0}};
                    quo     <= {NW{1'b0}};
                    cnt     <= NW[7:0];
                    busy    <= 1'b1;
                end
            end else if (busy) begin
                rem    <= fit ? trial - {1'b0, denHold} : trial;
                quo    <= {quo[NW-2:0], fit};
                shiftN <= {shiftN[NW-2:0], 1'b0};
                cnt    <= cnt - 8'h01;
                if (cnt == 8'h01) begin
                    busy <= 1'b0;
                end
            end else if (cnt == 8'h00 && denHold != {DW{1'b0}}) begin
                duty    <= (quo >= {{(NW-QW-1){1'b0}}, FULL}) ? FULL : quo[QW:0];
                done    <= 1'b1;
                denHold <= {DW{1'b0}};
            end
        end
    end

endmodule

`default_nettype wire

//--- dcpid_position.v
`timescale 1ns/1ps
`default_nettype none
`include "dcpid_map.vh"

// How it works
// - Position is the controlled quantity: a running setpoint is compared with the encoder count.
// - Error is setpoint minus measured position, action is Kp*E plus Ki*sum(E) plus Kd*dE.
// - The action sets the duty cycle of the PWM driving the motor winding.
// - Duty is action times nominal voltage over supply voltage times encoder counts per rev.
// - Each gain is an unsigned 16-bit integer with internal scaling.
// - Kp of one gives full duty at an error of 256 revolutions.
// - Ki of one gives full duty at an accumulated error of 52.5 revolution-seconds.
// - Kd of one gives full duty at a speed mismatch of 96000 rpm.
// - The move is done when the shaft reaches the target, while regulation carries on.
// - Emergency stop halts the shaft at once with no ramp.
// - An enabled limit switch stop is always immediate.
// - Soft stop with acceleration on ramps speed down at the deceleration value.
// - Soft stop with acceleration off acts as an emergency stop.
// - With acceleration on, speed ramps up, cruises, ramps down, or goes straight to ramp down.
module dcpid_position #(
    parameter PERIOD_CYC = `DCPID_PERIOD_NS / `DCPID_CLK_NS,
    parameter PWMB       = 10
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    input  wire        ce,
    // Register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdData,
    // Encoder and limit pins
    input  wire        encA,
    input  wire        encB,
    input  wire        limLeft,
    input  wire        limRight,
    // Supply voltage sample, same clock
    input  wire [15:0] supplyVolt,
    // Winding drive
    output reg         pwmOut,
    output reg         pwmDir
);

    // ----------------------------------------
    // Scaling constants
    // ----------------------------------------
    localparam         FR  = `DCPID_FRAC;
    localparam [63:0]  PPS = 64'd1000000000 / `DCPID_PERIOD_NS;
    localparam [63:0]  IS64 = ((64'd1 << FR) * 64'd10) / (`DCPID_I_FULL_X10 * PPS);
    localparam [63:0]  DS64 = ((64'd1 << FR) * 64'd60 * PPS) / `DCPID_D_FULL_RPM;
    localparam signed [23:0] ISC = IS64[23:0];
    localparam signed [31:0] DSC = DS64[31:0];
    localparam signed [39:0] IMAX = 40'sh7fffffffff;
    localparam signed [39:0] IMIN = -40'sh7fffffffff;
    localparam [1:0] P_IDLE = 2'h0;
    localparam [1:0] P_RUN  = 2'h1;
    localparam [1:0] P_SOFT = 2'h2;

    function [31:0] absDiff;
        input [31:0] a;
        input [31:0] b;
        begin
            absDiff = ($signed(a) >= $signed(b)) ? a - b : b - a;
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [2:0]  ctrl;
    reg [31:0] target;
    reg [31:0] speed;
    reg [31:0] accel;
    reg [31:0] decel;
    reg [15:0] kp;
    reg [15:0] ki;
    reg [15:0] kd;
    reg [15:0] unom;
    reg [15:0] cpr;

    wire wrCmd = regWr && regAddr == `DCPID_REG_CMD;
    wire cmdMove  = wrCmd && regWrData[`DCPID_CMD_MOVE];
    wire cmdEstop = wrCmd && regWrData[`DCPID_CMD_ESTOP];
    wire cmdSstop = wrCmd && regWrData[`DCPID_CMD_SSTOP];
    wire accOn    = ctrl[`DCPID_CTRL_ACCEL];

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl   <= `DCPID_CTRL_RST;
            target <= 32'h0;
            speed  <= 32'h0;
            accel  <= 32'h0;
            decel  <= 32'h0;
            kp     <= 16'h0;
            ki     <= 16'h0;
            kd     <= 16'h0;
            unom   <= `DCPID_UNOM_RST;
            cpr    <= `DCPID_CPR_RST;
        end else if (ce && regWr) begin
            case (regAddr)
                `DCPID_REG_CTRL:   ctrl   <= regWrData[2:0];
                `DCPID_REG_TARGET: target <= regWrData;
                `DCPID_REG_SPEED:  speed  <= regWrData;
                `DCPID_REG_ACCEL:  accel  <= regWrData;
                `DCPID_REG_DECEL:  decel  <= regWrData;
                `DCPID_REG_KP:     kp     <= regWrData[15:0];
                `DCPID_REG_KI:     ki     <= regWrData[15:0];
                `DCPID_REG_KD:     kd     <= regWrData[15:0];
                `DCPID_REG_UNOM:   unom   <= regWrData[15:0];
                `DCPID_REG_CPR:    cpr    <= regWrData[15:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Pin synchronisers and encoder count
    // ----------------------------------------
    reg [1:0] syA;
    reg [1:0] syB;
    reg [1:0] syL;
    reg [1:0] syR;
    reg       prevA;
    reg       prevB;
    reg [31:0] measPos;
    wire encA2 = syA[1];
    wire encB2 = syB[1];
    wire moved = (encA2 ^ prevA) ^ (encB2 ^ prevB);
    wire upCnt = encA2 ^ prevB;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syA     <= 2'h0;
            syB     <= 2'h0;
            syL     <= 2'h0;
            syR     <= 2'h0;
            prevA   <= 1'b0;
            prevB   <= 1'b0;
            measPos <= 32'h0;
        end else if (ce) begin
            syA   <= {syA[0], encA};
            syB   <= {syB[0], encB};
            syL   <= {syL[0], limLeft};
            syR   <= {syR[0], limRight};
            prevA <= encA2;
            prevB <= encB2;
            // Double-step glitches are dropped rather than guessed
            if (moved) begin
                measPos <= upCnt ? measPos + 32'h1 : measPos - 32'h1;
            end
        end
    end

    // ----------------------------------------
    // Control period tick
    // ----------------------------------------
    reg [31:0] tickCnt;
    wire       tick = tickCnt == PERIOD_CYC - 1;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt <= 32'h0;
        end else if (ce) begin
            tickCnt <= tick ? 32'h0 : tickCnt + 32'h1;
        end
    end

    // ----------------------------------------
    // Setpoint profile and stops
    // ----------------------------------------
    reg [1:0]  pState;
    reg [47:0] setFine;
    reg [31:0] vel;
    reg        dirUp;
    reg        moveDone;
    reg        limHit;
    wire [31:0] setPos = setFine[47:16];
    wire [31:0] remain = absDiff(target, setPos);
    wire [95:0] brakeL = {remain, 16'h0} * {decel, 1'b0};
    wire [95:0] brakeR = vel * vel;
    wire        brake  = accOn && brakeL <= brakeR;
    wire        land   = {16'h0, remain, 16'h0} <= {16'h0, vel} || (brake && vel <= decel);
    wire [31:0] velUp  = (vel + accel > speed || vel + accel < vel) ? speed : vel + accel;
    wire [31:0] velRun = !accOn ? speed : brake ? vel - decel : velUp;
    wire [31:0] velSoft = vel > decel ? vel - decel : 32'h0;
    wire        limStop = pState != P_IDLE && ((ctrl[`DCPID_CTRL_STOPL] && syL[1] && !dirUp)
                          || (ctrl[`DCPID_CTRL_STOPR] && syR[1] && dirUp));
    wire [47:0] stepV  = {16'h0, pState == P_SOFT ? velSoft : velRun};

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pState   <= P_IDLE;
            setFine  <= 48'h0;
            vel      <= 32'h0;
            dirUp    <= 1'b1;
            moveDone <= 1'b0;
            limHit   <= 1'b0;
        end else if (ce) begin
            // immediate halt: hold where the shaft is now
            if (cmdEstop || limStop || (cmdSstop && !accOn)) begin
                pState   <= P_IDLE;
                vel      <= 32'h0;
                setFine  <= {measPos, 16'h0};
                limHit   <= limHit | limStop;
                moveDone <= 1'b0;
            end else if (cmdSstop) begin
                if (pState != P_IDLE) begin
                    pState <= P_SOFT;
                end
            end else if (cmdMove) begin
                pState   <= P_RUN;
                dirUp    <= $signed(target) >= $signed(setPos);
                moveDone <= 1'b0;
                limHit   <= 1'b0;
                if (!accOn) begin
                    vel <= speed;
                end
            end else if (tick) begin
                case (pState)
                    P_RUN: begin
                        if (land) begin
                            setFine <= {target, 16'h0};
                            vel     <= 32'h0;
                            pState  <= P_IDLE;
                        end else begin
                            vel     <= velRun;
                            setFine <= dirUp ? setFine + stepV : setFine - stepV;
                        end
                    end
                    P_SOFT: begin
                        vel     <= velSoft;
                        setFine <= dirUp ? setFine + stepV : setFine - stepV;
                        if (velSoft == 32'h0) begin
                            pState <= P_IDLE;
                        end
                    end
                    default: ;
                endcase
            end
            // done on shaft arrival, regulation keeps running
            if (!cmdMove && pState == P_IDLE && setPos == target && measPos == target && !limHit) begin
                moveDone <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // PID law
    // ----------------------------------------
    reg signed [39:0] errSum;
    reg signed [31:0] errPrev;
    reg signed [79:0] uAct;
    reg               uStart;
    reg               uNeg;
    wire signed [31:0] err  = $signed(setPos - measPos);
    wire signed [31:0] dErr = err - errPrev;
    wire signed [40:0] sumW = errSum + err;
    wire signed [39:0] sumN = sumW > IMAX ? IMAX : sumW < IMIN ? IMIN : sumW[39:0];
    // proportional scaling by the 256-revolution span
    wire signed [79:0] pTerm = ($signed({1'b0, kp}) * err) <<< (FR - `DCPID_P_SHIFT);
    wire signed [79:0] iTerm = $signed({1'b0, ki}) * errSum * ISC;
    wire signed [79:0] dTerm = $signed({1'b0, kd}) * dErr * DSC;
    wire        [79:0] uMag  = uAct < 0 ? -uAct : uAct;
    wire        [95:0] numW  = uMag * unom;
    wire        [31:0] denW  = supplyVolt * cpr;
    wire        [PWMB:0] normDuty;
    wire               normDone;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            errSum  <= 40'sh0;
            errPrev <= 32'sh0;
            uAct    <= 80'sh0;
            uStart  <= 1'b0;
            uNeg    <= 1'b0;
        end else if (ce) begin
            uStart <= tick;
            if (tick) begin
                errSum  <= sumN;
                errPrev <= err;
                uAct    <= pTerm + iTerm + dTerm;
            end
            if (uStart) begin
                uNeg <= uAct < 0;
            end
        end
    end

    // normalise by nominal, supply and counts per rev
    dcpid_duty_norm #(
        .NW (96 - FR + PWMB),
        .DW (32),
        .QW (PWMB)
    ) u_norm (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .start(uStart),
        .num  (numW[95:FR-PWMB]),
        .den  (denW),
        .done (normDone),
        .duty (normDuty)
    );

    // ----------------------------------------
    // PWM output
    // ----------------------------------------
    reg [PWMB-1:0] pwmCnt;
    reg [PWMB:0]   dutyNew;
    reg [PWMB:0]   dutyCur;
    reg            dirNew;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwmCnt  <= {PWMB{1'b0}};
            dutyNew <= {(PWMB+1){1'b0}};
            dutyCur <= {(PWMB+1){1'b0}};
            dirNew  <= 1'b0;
            pwmOut  <= 1'b0;
            pwmDir  <= 1'b0;
        end else if (ce) begin
            pwmCnt <= pwmCnt + 1'b1;
            if (normDone) begin
                dutyNew <= normDuty;
                dirNew  <= uNeg;
            end
            // New duty only at frame start, avoiding runt pulses
            if (pwmCnt == {PWMB{1'b0}}) begin
                dutyCur <= dutyNew;
                pwmDir  <= dirNew;
            end
            pwmOut <= {1'b0, pwmCnt} < dutyCur;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 32'h0;
        end else if (ce) begin
            regRdData <= 32'h0;
            if (regRd) begin
                case (regAddr)
                    `DCPID_REG_CTRL:   regRdData <= {29'h0, ctrl};
                    `DCPID_REG_TARGET: regRdData <= target;
                    `DCPID_REG_SPEED:  regRdData <= speed;
                    `DCPID_REG_ACCEL:  regRdData <= accel;
                    `DCPID_REG_DECEL:  regRdData <= decel;
                    `DCPID_REG_KP:     regRdData <= {16'h0, kp};
                    `DCPID_REG_KI:     regRdData <= {16'h0, ki};
                    `DCPID_REG_KD:     regRdData <= {16'h0, kd};
                    `DCPID_REG_UNOM:   regRdData <= {16'h0, unom};
                    `DCPID_REG_CPR:    regRdData <= {16'h0, cpr};
                    `DCPID_REG_STATUS: regRdData <= {27'h0, dirUp, pState == P_SOFT, limHit,
                                                     moveDone, pState != P_IDLE};
                    `DCPID_REG_POS:    regRdData <= measPos;
                    `DCPID_REG_SETPT:  regRdData <= setPos;
                    `DCPID_REG_DUTY:   regRdData <= {20'h0, dirNew, dutyNew};
                    default:           regRdData <= 32'h0;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

//--- dcpid_position_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcpid_map.vh"

module dcpid_position_props #(
    parameter PERIOD_CYC = 200,
    parameter PWMB       = 10
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        ce,
    // Register port
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    // Pins
    input wire logic        encA,
    input wire logic        encB,
    input wire logic        limLeft,
    input wire logic        limRight,
    input wire logic [15:0] supplyVolt,
    input wire logic        pwmOut,
    input wire logic        pwmDir
);
    logic accelOn;
    wire  stRd = regRd && regAddr == `DCPID_REG_STATUS;
    wire  cmdWr = regWr && regAddr == `DCPID_REG_CMD;

    // Ramp enable shadow: the soft stop modes differ only by it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            accelOn <= 1'b1;
        end else if (ce && regWr && regAddr == `DCPID_REG_CTRL) begin
            accelOn <= regWrData[`DCPID_CTRL_ACCEL];
        end
    end

    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ---
    // Checks
    // ---
    kp_readback_a: assert property (
        (regWr && regAddr == `DCPID_REG_KP) ##1 !regWr ##1 (regRd && regAddr == `DCPID_REG_KP)
        |=> regRdData == {16'h0000, $past(regWrData[15:0], 3)}) else $error("gain readback wrong");
    gain_width_a: assert property (
        regRd && (regAddr == `DCPID_REG_KI || regAddr == `DCPID_REG_KD) |=> regRdData[31:16] == 16'h0000)
        else $error("gain wider than 16 bits");
    duty_sat_a: assert property (
        regRd && regAddr == `DCPID_REG_DUTY |=> regRdData[10:0] <= 11'h400 && regRdData[31:12] == 20'h0)
        else $error("duty above full scale");
    estop_halt_a: assert property (
        (cmdWr && regWrData[`DCPID_CMD_ESTOP]) ##[1:3] stRd |=> !regRdData[`DCPID_ST_RUN])
        else $error("emergency stop left profile running");
    soft_immediate_a: assert property (
        (cmdWr && regWrData[`DCPID_CMD_SSTOP] && !accelOn) ##[1:3] stRd
        |=> !regRdData[`DCPID_ST_RUN] && !regRdData[`DCPID_ST_SOFT]) else $error("soft stop not immediate");
    soft_ramp_a: assert property (
        (cmdWr && regWrData[`DCPID_CMD_SSTOP] && !regWrData[`DCPID_CMD_ESTOP] && accelOn) ##[1:3] stRd
        |=> regRdData[`DCPID_ST_SOFT] == regRdData[`DCPID_ST_RUN]) else $error("soft stop without ramp");
    done_idle_a: assert property (
        stRd |=> !(regRdData[`DCPID_ST_DONE] && regRdData[`DCPID_ST_RUN])) else $error("done while running");
    ctrl_read_a: assert property (
        regRd && regAddr == `DCPID_REG_CTRL
        |=> regRdData[31:3] == 29'h0 && regRdData[`DCPID_CTRL_ACCEL] == accelOn) else $error("ctrl readback wrong");
endmodule

`default_nettype wire

//--- dcpid_motor_model.sv
`timescale 1ns/1ps
`default_nettype none

module dcpid_motor_model #(
    parameter STEP = 64
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Jammed shaft ignores drive
    input  wire logic hold,
    // Winding
    input  wire logic pwmOut,
    input  wire logic pwmDir,
    // Encoder
    output wire logic encA,
    output wire logic encB
);
    int         acc;
    int         nxt;
    logic [1:0] phase;

    // No inertia: one count per STEP driven cycles keeps gains stable
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc <= 0;
            phase <= 2'd0;
        end else if (pwmOut && !hold) begin
            nxt = acc + (pwmDir ? -1 : 1);
            if (nxt >= STEP || nxt <= -STEP) begin
                acc <= 0;
                phase <= phase + (pwmDir ? 2'd3 : 2'd1);
            end else begin
                acc <= nxt;
            end
        end
    end

    assign encA = phase[0] ^ phase[1];
    assign encB = phase[1];
endmodule

`default_nettype wire

//--- dcpid_position_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcpid_map.vh"

module dcpid_position_test;
    localparam PCYC = 200;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        limRight = 1'b0;
    logic        hold = 1'b1;
    logic [15:0] supplyVolt = 16'h0018;
    logic        rdLate = 1'b0;
    logic        sawUp = 1'b0;
    logic        sawDown = 1'b0;
    logic [31:0] lastRd;
    logic [63:0] expQ[$];
    wire  [31:0] regRdData;
    wire         encA;
    wire         encB;
    wire         pwmOut;
    wire         pwmDir;
    int          errorCnt = 0;
    int          compares = 0;

    always #2.5 clk = ~clk;

    dcpid_position #(.PERIOD_CYC(PCYC), .PWMB(10)) DUT (
        .clk(clk), .rstn(rstn), .ce(1'b1), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .encA(encA), .encB(encB), .limLeft(1'b0),
        .limRight(limRight), .supplyVolt(supplyVolt), .pwmOut(pwmOut), .pwmDir(pwmDir));
    dcpid_motor_model #(.STEP(64)) motor (
        .clk(clk), .rstn(rstn), .hold(hold), .pwmOut(pwmOut), .pwmDir(pwmDir), .encA(encA), .encB(encB));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ---
    // Read watcher: note is {mask, expected}; zero mask only captures
    // ---
    always @(posedge clk) begin
        rdLate <= regRd;
        if (pwmOut === 1'b1 && !hold) begin
            sawUp <= sawUp | (pwmDir === 1'b0);
            sawDown <= sawDown | (pwmDir === 1'b1);
        end
        if (rdLate) begin
            lastRd = regRdData;
            if (expQ[0][63:32] != 32'h0) chk(regRdData & expQ[0][63:32], expQ[0][31:0]);
            void'(expQ.pop_front());
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back({m, e});
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic duty(input logic [15:0] kp, input logic [15:0] un, input logic [15:0] sv, input int t);
        longint a;
        longint m;
        a = (t < 0) ? -t : t;
        m = 4 * kp * a * un / (sv * 16);
        if (m > 1024) m = 1024;
        wr(`DCPID_REG_KP, {16'h0, kp});
        wr(`DCPID_REG_UNOM, {16'h0, un});
        supplyVolt <= sv;
        wr(`DCPID_REG_TARGET, t);
        wr(`DCPID_REG_CMD, 32'h1);
        repeat (3 * PCYC) @(posedge clk);
        rd(`DCPID_REG_DUTY, 32'hfff, {20'h0, t < 0, m[10:0]});
    endtask

    task automatic stop(input logic [31:0] ctrl, input logic [31:0] cmd, input logic [31:0] st);
        wr(`DCPID_REG_CTRL, ctrl);
        wr(`DCPID_REG_SPEED, 32'h10000);
        wr(`DCPID_REG_TARGET, 32'd9000);
        wr(`DCPID_REG_CMD, 32'h1);
        repeat (4 * PCYC) @(posedge clk);
        rd(`DCPID_REG_STATUS, 32'h1, 32'h1);
        if (cmd == 32'h0) limRight <= 1'b1;
        else wr(`DCPID_REG_CMD, cmd);
        repeat ((cmd == 32'h0) ? 4 : 1) @(posedge clk);
        rd(`DCPID_REG_STATUS, 32'hd, st);
        rd(`DCPID_REG_POS, 32'h0, 32'h0);
        rd(`DCPID_REG_SETPT, 32'hffffffff, lastRd);
        limRight <= 1'b0;
    endtask

    task automatic move(input logic [31:0] t);
        int n;
        n = 0;
        wr(`DCPID_REG_TARGET, t);
        wr(`DCPID_REG_CMD, 32'h1);
        rd(`DCPID_REG_STATUS, 32'h0, 32'h0);
        while (lastRd[`DCPID_ST_DONE] !== 1'b1 && n < 2000) begin
            repeat (20) @(posedge clk);
            rd(`DCPID_REG_STATUS, 32'h0, 32'h0);
            n++;
        end
        chk({31'h0, lastRd[`DCPID_ST_DONE]}, 32'h1);
        rd(`DCPID_REG_SETPT, 32'hffffffff, t);
        rd(`DCPID_REG_POS, 32'hffffffff, t);
    endtask

    task automatic wrapUp();
        if (errorCnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        errorCnt++;
        wrapUp();
    end

    initial begin
        logic [31:0] v;
        logic [31:0] keep;
        void'($urandom(32'h300e418f));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(`DCPID_REG_CTRL, 32'hffffffff, {29'h0, `DCPID_CTRL_RST});
        rd(`DCPID_REG_UNOM, 32'hffffffff, {16'h0, `DCPID_UNOM_RST});
        rd(`DCPID_REG_CPR, 32'hffffffff, {16'h0, `DCPID_CPR_RST});
        rd(`DCPID_REG_CMD, 32'hffffffff, 32'h0);
        rd(8'h3c, 32'hffffffff, 32'h0);
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 32'hffffffff : $urandom;
            wr(8'(`DCPID_REG_KP + 4 * i), v);
            rd(8'(`DCPID_REG_KP + 4 * i), 32'hffffffff, {16'h0, v[15:0]});
        end
        wr(`DCPID_REG_KI, 32'h0);
        wr(`DCPID_REG_KD, 32'h0);
        wr(`DCPID_REG_CPR, 32'd16);
        wr(`DCPID_REG_CTRL, 32'h0);
        wr(`DCPID_REG_SPEED, 32'h7fff0000);
        duty(16'd1, 16'd24, 16'd24, 4096);
        duty(16'd1, 16'd24, 16'd24, -2048);
        duty(16'd1, 16'd24, 16'd48, 2048);
        duty(16'd1, 16'd48, 16'd24, 1024);
        duty(16'd3, 16'd24, 16'd24, 8192);
        duty(16'($urandom_range(7, 1)), 16'd24, 16'd24, 512);
        wr(`DCPID_REG_ACCEL, 32'h4000);
        wr(`DCPID_REG_DECEL, 32'h2000);
        stop(32'h1, 32'h2, 32'h0);
        stop(32'h0, 32'h4, 32'h0);
        stop(32'h5, 32'h0, 32'h4);
        hold <= 1'b0;
        wr(`DCPID_REG_KP, 32'd64);
        wr(`DCPID_REG_CTRL, 32'h0);
        wr(`DCPID_REG_SPEED, 32'h20000);
        move(32'd96);
        chk({31'h0, sawUp}, 32'h1);
        move(32'd80);
        chk({31'h0, sawDown}, 32'h1);
        wr(`DCPID_REG_CTRL, 32'h1);
        wr(`DCPID_REG_TARGET, 32'd2000);
        wr(`DCPID_REG_CMD, 32'h1);
        repeat (10 * PCYC) @(posedge clk);
        wr(`DCPID_REG_CMD, 32'h4);
        rd(`DCPID_REG_STATUS, 32'h9, 32'h9);
        repeat (12 * PCYC) @(posedge clk);
        rd(`DCPID_REG_STATUS, 32'h1, 32'h1);
        repeat (6 * PCYC) @(posedge clk);
        rd(`DCPID_REG_STATUS, 32'h1, 32'h0);
        rd(`DCPID_REG_SETPT, 32'h0, 32'h0);
        keep = lastRd;
        repeat (3 * PCYC) @(posedge clk);
        rd(`DCPID_REG_SETPT, 32'hffffffff, keep);
        wrapUp();
    end
endmodule

bind dcpid_position dcpid_position_props #(.PERIOD_CYC(PERIOD_CYC), .PWMB(PWMB)) props (
    .clk(clk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .encA(encA), .encB(encB), .limLeft(limLeft),
    .limRight(limRight), .supplyVolt(supplyVolt), .pwmOut(pwmOut), .pwmDir(pwmDir));

`default_nettype wire
